// ---- common/sru_pkg.sv ----
package sru_pkg;

    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int LEN_W = 2;
    localparam int MODE_W = 2;

    // Shortest character; the length code adds to it
    localparam logic [CNT_W-1:0] CHAR_BASE = 4'h5;

    // Values of mode bits 13 and 12 as written by the program
    localparam logic [MODE_W-1:0] MODE_EXT_SYNC = 2'h2;
    localparam logic [MODE_W-1:0] MODE_ISOC = 2'h0;

    localparam logic [DATA_W-1:0] BUF_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

    // Local clock and modem bit clock, in ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    // Local clocks per link bit, rounded down
    localparam int CLKS_PER_BIT = LINK_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_WAIT_LOW,
        RX_FRAMING
    } sru_rx_state_t;

endpackage : sru_pkg

// ---- core/sru_sync2.sv ----
`timescale 1ns/10ps
`default_nettype none

module sru_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : sru_sync2

`default_nettype wire

// ---- core/sru_framer.sv ----
`timescale 1ns/10ps
`default_nettype none

module sru_framer
    import sru_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic sample,
    input wire logic bit_in,
    input wire logic [LEN_W-1:0] char_len,
    input wire logic parity_en,
    output logic [DW-1:0] char_data,
    output logic parity_bit,
    output logic char_done
);

    logic [CNT_W-1:0] cnt_q;
    logic [DW-1:0] data_q;
    logic par_q;
    logic done_q;
    logic [CNT_W-1:0] n_data;
    logic [CNT_W-1:0] last_idx;
    logic at_last;

    assign n_data = CHAR_BASE + CNT_W'(char_len);
    // Parity bit, when present, follows the last data bit
    assign last_idx = parity_en ? n_data : n_data - CNT_STEP;
    assign at_last = (cnt_q == last_idx);

    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            cnt_q <= CNT_RESET;
        end else if (sample) begin
            cnt_q <= at_last ? CNT_RESET : cnt_q + CNT_STEP;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DW; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    data_q[i] <= 1'b0;
                end else if (enable && sample && cnt_q == CNT_W'(i)) begin
                    data_q[i] <= bit_in;
                end else if (enable && sample && cnt_q == CNT_RESET) begin
                    data_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            par_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (enable && sample && parity_en && cnt_q == n_data) begin
                par_q <= bit_in;
            end
            done_q <= enable && sample && at_last;
        end
    end

    assign char_data = data_q;
    assign parity_bit = par_q;
    assign char_done = done_q;

endmodule : sru_framer

`default_nettype wire

// ---- core/sru_receiver.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// - A character raises data ready and the ready pulse together, and the ready pulse sets the receive-done interrupt request.
// - A character arriving while the buffer is unread overwrites it and sets overrun, its error line and the error summary.
// - A buffer read makes the clear pulse, which resets data ready and overrun.
// - Receive done is cleared on the trailing edge of the buffer read select.
// - Loading mode bits 13:12 as 1,0 clears the sync interrupt flop and sets the sync mode flop.
// - In external sync mode the receiver goes to synchronized on the first low receive clock after hunt enable is set.
// - Hunt enable raises receiver active on the next clock, and in external sync mode sync achieved follows on the next low receive clock.
// - Receiver active gates receive done, and a high strip/start line starts framing on the next bit.
// - A sync character asserts match, data ready, ready and compare hit in one cycle, and with strip on and no error discard, which clears data ready.
// - Discard blocks receive done, so a matched sync character is stripped without interrupt.
module sru_receiver
    import sru_pkg::*;
#(
    parameter int DW = DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_clk_pin,
    input wire logic rx_data_pin,
    input wire logic mode_load,
    input wire logic [MODE_W-1:0] mode_bits,
    input wire logic [LEN_W-1:0] char_len,
    input wire logic parity_en,
    input wire logic parity_odd,
    input wire logic hunt_enable,
    input wire logic strip_enable,
    input wire logic [DW-1:0] sync_char,
    input wire logic buffer_read_select,
    output logic [DW-1:0] receive_buffer,
    output logic data_ready_flag,
    output logic overrun_flag,
    output logic overrun_error_line,
    output logic parity_error_flag,
    output logic receive_error,
    output logic receive_done,
    output logic receiver_active,
    output logic sync_achieved,
    output logic sync_mode,
    output logic sync_interrupt_ff,
    output logic match_detect,
    output logic ready_pulse,
    output logic compare_hit,
    output logic discard,
    output logic clear_ready_pulse
);

    logic [1:0] pins_sync;
    logic rx_clk_s;
    logic rx_data_s;
    logic rx_clk_prev_q;
    logic rx_rise;
    logic rx_fall;

    sru_rx_state_t state_q;
    sru_rx_state_t state_d;

    logic sync_mode_q;
    logic sync_int_q;
    logic [DW-1:0] buf_q;
    logic dr_q;
    logic ovr_q;
    logic par_err_q;
    logic mdet_q;
    logic ready_q;
    logic done_q;
    logic sel_prev_q;

    logic ss_line;
    logic [DW-1:0] char_data;
    logic parity_bit;
    logic char_done;
    logic [DW-1:0] len_mask;
    logic is_match;
    logic par_good;
    logic read_rise;
    logic read_fall;
    logic unread;
    logic done_set;

    sru_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({rx_clk_pin, rx_data_pin}),
        .sync_out(pins_sync)
    );

    assign rx_clk_s = pins_sync[1];
    assign rx_data_s = pins_sync[0];
    assign rx_rise = rx_clk_s && !rx_clk_prev_q;
    assign rx_fall = !rx_clk_s && rx_clk_prev_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_clk_prev_q <= 1'b0;
        end else begin
            rx_clk_prev_q <= rx_clk_s;
        end
    end

    // Sync mode flop follows each mode load; sync interrupt flop clears only on MODE_EXT_SYNC or MODE_ISOC loads
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_mode_q <= 1'b0;
            sync_int_q <= 1'b0;
        end else if (mode_load) begin
            sync_mode_q <= (mode_bits == MODE_EXT_SYNC);
            if (mode_bits == MODE_EXT_SYNC || mode_bits == MODE_ISOC) begin
                sync_int_q <= 1'b0;
            end
        end
    end

    // Hunt sequence; no character search in external sync mode
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            RX_IDLE: begin
                if (hunt_enable) begin
                    state_d = RX_WAIT_LOW;
                end
            end
            RX_WAIT_LOW: begin
                if (!hunt_enable) begin
                    state_d = RX_IDLE;
                end else if (sync_mode_q && rx_fall) begin
                    state_d = RX_FRAMING;
                end
            end
            RX_FRAMING: begin
                if (!hunt_enable || !sync_mode_q) begin
                    state_d = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= RX_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign receiver_active = (state_q != RX_IDLE);
    assign sync_achieved = (state_q == RX_FRAMING);
    assign ss_line = sync_achieved && sync_mode_q;

    sru_framer #(
        .DW(DW)
    ) u_framer (
        .clk(clk),
        .rst(rst),
        .enable(ss_line),
        .sample(rx_rise),
        .bit_in(rx_data_s),
        .char_len(char_len),
        .parity_en(parity_en),
        .char_data(char_data),
        .parity_bit(parity_bit),
        .char_done(char_done)
    );

    genvar i;
    generate
        for (i = 0; i < DW; i++) begin : g_mask
            assign len_mask[i] = (CNT_W'(i) < CHAR_BASE + CNT_W'(char_len));
        end
    endgenerate

    assign is_match = (char_data == (sync_char & len_mask));
    assign par_good = !parity_en || ((^{char_data, parity_bit}) == parity_odd);

    // Host read logic shares this clock, so no synchroniser
    assign read_rise = buffer_read_select && !sel_prev_q;
    assign read_fall = !buffer_read_select && sel_prev_q;
    // Error guard keeps a bad sync character visible to the program
    assign compare_hit = ready_q && mdet_q;
    assign discard = compare_hit && strip_enable && !receive_error;
    assign clear_ready_pulse = read_rise || discard;
    assign unread = dr_q && !clear_ready_pulse;
    assign done_set = ready_q && receiver_active && !discard;

    always_ff @(posedge clk) begin
        if (rst) begin
            sel_prev_q <= 1'b0;
            buf_q <= BUF_RESET;
            mdet_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            sel_prev_q <= buffer_read_select;
            ready_q <= char_done;
            if (char_done) begin
                buf_q <= char_data;
                mdet_q <= is_match;
            end
        end
    end

    // Hardware set wins over a same-cycle clear on data ready and parity error; a same-cycle read keeps overrun from setting
    always_ff @(posedge clk) begin
        if (rst) begin
            dr_q <= 1'b0;
            ovr_q <= 1'b0;
            par_err_q <= 1'b0;
        end else begin
            dr_q <= char_done || (dr_q && !clear_ready_pulse);
            ovr_q <= (char_done && unread)
                || (ovr_q && !read_rise);
            par_err_q <= (char_done && !par_good)
                || (par_err_q && !read_rise);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_set || (done_q && !read_fall);
        end
    end

    assign receive_buffer = buf_q;
    assign data_ready_flag = dr_q;
    assign overrun_flag = ovr_q;
    assign overrun_error_line = ovr_q;
    assign parity_error_flag = par_err_q;
    assign receive_error = ovr_q || par_err_q;
    assign receive_done = done_q;
    assign ready_pulse = ready_q;
    assign match_detect = mdet_q;
    assign sync_mode = sync_mode_q;
    assign sync_interrupt_ff = sync_int_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ready_raise_a: assert property (
        char_done |=> data_ready_flag ##0 ready_pulse)
        else $error("data ready or ready pulse missing after character");

    done_raise_a: assert property (
        (char_done && receiver_active && !strip_enable) |=> ##1 receive_done)
        else $error("receive done not raised for character");

    overrun_set_a: assert property (
        (char_done && data_ready_flag && !clear_ready_pulse)
        |=> (overrun_flag && overrun_error_line && receive_error))
        else $error("overrun not flagged on unread buffer");

    buffer_load_a: assert property (
        char_done |=> (receive_buffer == $past(char_data)))
        else $error("buffer not overwritten by new character");

    read_clear_a: assert property (
        ($rose(buffer_read_select) && !char_done)
        |-> clear_ready_pulse ##1 (!data_ready_flag && !overrun_flag))
        else $error("buffer read did not clear ready and overrun");

    done_fall_a: assert property (
        ($fell(buffer_read_select) && !done_set) |=> !receive_done)
        else $error("receive done not cleared on read select trailing edge");

    ext_mode_a: assert property (
        (mode_load && mode_bits == MODE_EXT_SYNC)
        |=> (sync_mode && !sync_interrupt_ff))
        else $error("external sync mode load not applied");

    active_rise_a: assert property (
        ($rose(hunt_enable) && !receiver_active) |=> receiver_active)
        else $error("receiver active late after hunt enable");

    sync_low_a: assert property (
        (state_q == RX_WAIT_LOW && hunt_enable && sync_mode && rx_fall)
        |=> sync_achieved)
        else $error("sync not achieved on low receive clock");

    strip_block_a: assert property (
        discard |=> (!$rose(receive_done) && !data_ready_flag) [*2])
        else $error("stripped sync character reached the program");

    idle_done_a: assert property (
        (!receiver_active && !receive_done) |=> !receive_done)
        else $error("receive done set while receiver inactive");

    err_sum_a: assert property (
        $fell(receive_error) |-> ($past(read_rise) && !overrun_flag))
        else $error("error summary dropped without a read");

endmodule : sru_receiver

`default_nettype wire

// ---- verif/sru_modem.sv ----
`timescale 1ns/10ps
`default_nettype none

module sru_modem #(
    parameter int HALF_NS = 160
) (
    output var logic rx_clk,
    output var logic rx_data
);
    initial begin
        rx_clk = 1'h1;
        rx_data = 1'h1;
    end

    // Bits change while the clock is low and hold through its rise;
    // the clock stands high between frames
    task automatic send(input logic [8:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            rx_clk = 1'h0;
            rx_data = bits[i];
            #(HALF_NS);
            rx_clk = 1'h1;
            #(HALF_NS);
        end
        // Hold time is over: show a changed level, never a stale bit
        rx_data = ~rx_data;
    endtask : send
endmodule : sru_modem

`default_nettype wire

// ---- verif/tb_sru_receiver.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_sru_receiver;
    import sru_pkg::*;
    logic clk, rst, rx_clk, rx_data, mode_load, parity_en, parity_odd;
    logic hunt_enable, strip_enable, sel;
    logic [MODE_W-1:0] mode_bits;
    logic [LEN_W-1:0] char_len;
    logic [DATA_W-1:0] sync_char, rbuf;
    logic dr, ovr, ovl, pe, rerr, rdone, ract, sach, smode, sint;
    logic mdet, rdy, hit, disc, clr;
    int fails = 0;
    int n_tests = 0;
    int c_rdy = 0;
    int c_hit = 0;
    int c_disc = 0;
    int c_clr = 0;

    sru_receiver i_sru_receiver (.clk(clk), .rst(rst), .rx_clk_pin(rx_clk),
        .rx_data_pin(rx_data), .mode_load(mode_load), .mode_bits(mode_bits),
        .char_len(char_len), .parity_en(parity_en), .parity_odd(parity_odd),
        .hunt_enable(hunt_enable), .strip_enable(strip_enable),
        .sync_char(sync_char), .buffer_read_select(sel),
        .receive_buffer(rbuf), .data_ready_flag(dr), .overrun_flag(ovr),
        .overrun_error_line(ovl), .parity_error_flag(pe),
        .receive_error(rerr), .receive_done(rdone), .receiver_active(ract),
        .sync_achieved(sach), .sync_mode(smode), .sync_interrupt_ff(sint),
        .match_detect(mdet), .ready_pulse(rdy), .compare_hit(hit),
        .discard(disc), .clear_ready_pulse(clr));

    sru_modem #(.HALF_NS(LINK_PERIOD_NS / 2)) i_sru_modem (
        .rx_clk(rx_clk), .rx_data(rx_data));

    initial begin
        clk = 1'h0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    // One-cycle pulses are counted so they can be checked later
    always @(posedge clk) begin
        c_rdy <= c_rdy + int'(rdy === 1'h1);
        c_hit <= c_hit + int'(hit === 1'h1);
        c_disc <= c_disc + int'(disc === 1'h1);
        c_clr <= c_clr + int'(clr === 1'h1);
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic test_done;
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // Sends n bits LSB first, off the clock edge, and waits for ready
    task automatic rx_bits(input logic [8:0] b, input int n);
        int k;
        int r0;
        r0 = c_rdy;
        k = 0;
        #1;
        i_sru_modem.send(b, n);
        while (c_rdy == r0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (c_rdy == r0) begin
            fails++;
            test_done();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : rx_bits

    // Even parity; pbad flips the parity bit
    task automatic rx_char(input logic [7:0] d, input logic pbad);
        rx_bits({^d ^ pbad, d}, 9);
    endtask : rx_char

    task automatic rd_buf;
        int c0;
        c0 = c_clr;
        @(posedge clk) sel <= 1'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("clear", 8'h01, 8'(c_clr - c0));
        chk("ready", 8'h00, 8'(dr));
        chk("overrun", 8'h00, 8'(ovr));
        chk("err", 8'h00, 8'(rerr));
        chk("done_held", 8'h01, 8'(rdone));
        @(posedge clk) sel <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        chk("done_clr", 8'h00, 8'(rdone));
    endtask : rd_buf

    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        rst = 1'h1;
        mode_load = 1'h0;
        mode_bits = MODE_ISOC;
        char_len = 2'h3;
        parity_en = 1'h1;
        parity_odd = 1'h0;
        hunt_enable = 1'h0;
        strip_enable = 1'h1;
        sync_char = 8'h16;
        sel = 1'h0;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        chk("reset", 8'h00, {2'h0, dr, ovr, rdone, ract, sach, smode});
        @(posedge clk) mode_load <= 1'h1;
        @(posedge clk) mode_load <= 1'h0;
        #1;
        chk("iso_mode", 8'h00, 8'(smode));
        @(posedge clk) begin
            mode_load <= 1'h1;
            mode_bits <= MODE_EXT_SYNC;
        end
        @(posedge clk) mode_load <= 1'h0;
        #1;
        chk("sync_mode", 8'h01, 8'(smode));
        chk("sync_interrupt_ff", 8'h00, 8'(sint));
        @(posedge clk) hunt_enable <= 1'h1;
        @(posedge clk);
        #1;
        chk("active", 8'h01, 8'(ract));
        chk("no_sync", 8'h00, 8'(sach));
        // First character framed at once is a sync character: stripped
        rx_char(8'h16, 1'h0);
        chk("synced", 8'h01, 8'(sach));
        chk("buf_s", 8'h16, rbuf);
        chk("match", 8'h01, 8'(mdet));
        chk("hit", 8'h01, 8'(c_hit));
        chk("discard", 8'h01, 8'(c_disc));
        chk("rdy_s", 8'h00, 8'(dr));
        chk("done_s", 8'h00, 8'(rdone));
        rx_char(8'hA5, 1'h0);
        chk("buf_a", 8'hA5, rbuf);
        chk("rdy_a", 8'h01, 8'(dr));
        chk("done_a", 8'h01, 8'(rdone));
        chk("ovr_a", 8'h00, 8'(ovr));
        rx_char(8'h3C, 1'h0);
        chk("buf_o", 8'h3C, rbuf);
        chk("ovr_o", 8'h01, 8'(ovr));
        chk("ovl_o", 8'h01, 8'(ovl));
        chk("err_o", 8'h01, 8'(rerr));
        rd_buf();
        @(posedge clk) strip_enable <= 1'h0;
        rx_char(8'h16, 1'h0);
        chk("done_k", 8'h01, 8'(rdone));
        chk("disc_k", 8'h01, 8'(c_disc));
        rd_buf();
        @(posedge clk) strip_enable <= 1'h1;
        rx_char(8'h5A, 1'h1);
        chk("perr", 8'h01, 8'(pe));
        chk("err_p", 8'h01, 8'(rerr));
        rd_buf();
        chk("perr_c", 8'h00, 8'(pe));
        // Five data bits with odd parity, then eight bits without parity
        @(posedge clk) begin
            char_len <= 2'h0;
            parity_odd <= 1'h1;
        end
        rx_bits({3'h0, 1'h0, 5'h15}, 6);
        chk("buf_5", 8'h15, rbuf);
        chk("perr_5", 8'h00, 8'(pe));
        chk("rdy_5", 8'h01, 8'(dr));
        rd_buf();
        @(posedge clk) begin
            char_len <= 2'h3;
            parity_en <= 1'h0;
        end
        rx_bits({1'h0, 8'hC3}, 8);
        chk("buf_n", 8'hC3, rbuf);
        chk("perr_n", 8'h00, 8'(pe));
        rd_buf();
        chk("rdy_cnt", 8'h07, 8'(c_rdy));
        // Leaving external sync mode drops the synchronized condition
        @(posedge clk) begin
            mode_load <= 1'h1;
            mode_bits <= MODE_ISOC;
        end
        @(posedge clk) mode_load <= 1'h0;
        #1;
        chk("iso_clr", 8'h00, 8'(smode));
        chk("iso_intr", 8'h00, 8'(sint));
        @(posedge clk);
        #1;
        chk("iso_sync", 8'h00, 8'(sach));
        test_done();
    end
endmodule : tb_sru_receiver

`default_nettype wire
